/* File: hw/hsrc_pkg.sv */
package hsrc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int GATE_TIME_NS = 20480;
  localparam int GATE_CYC = (GATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GATE_W = 11;
  localparam logic [GATE_W-1:0] GATE_LAST = GATE_W'(GATE_CYC - 1);

  // ----------------------------------------------------------------
  // Counts and widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
  localparam logic [CNT_W-1:0] LOCK_TOL = 12'h002;
  localparam int RATE_W = 17;
  localparam logic [RATE_W-1:0] TX_MULT = 17'h00014;
  localparam int WORD_W = 20;
  localparam int BASE_W = 16;
  localparam int EXTRA_W = 4;
  localparam int COMP_W = 10;
  localparam int LUMA_LSB = 10;
  localparam int CHROMA_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic PAIR_RST = 1'b0;
  localparam logic [1:0] ACTIVE_RST = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 20'h00000;
  localparam logic [COMP_W-1:0] COMP_RST = 10'h000;
  localparam logic [RATE_W-1:0] RATE_RST = 17'h00000;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [GATE_W-1:0] GATE_RST = 11'h000;

endpackage : hsrc_pkg

/* File: hw/hsrc_edge_meter.sv */
`timescale 1ns/10ps
module hsrc_edge_meter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic raw_in,
  input wire logic win_end,
  input wire logic clear,
  output logic level,
  output logic rise,
  output logic [hsrc_pkg::CNT_W-1:0] meas
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic [hsrc_pkg::CNT_W-1:0] cnt;
    logic [hsrc_pkg::CNT_W-1:0] meas;
  } hsrc_meter_t;

  hsrc_meter_t m_q;
  hsrc_meter_t m_d;

  // ----------------------------------------------------------------
  // Synchroniser, edge finder and per-window edge count
  // ----------------------------------------------------------------
  always_comb begin
    m_d = m_q;
    m_d.s1 = raw_in;
    m_d.s2 = m_q.s1;
    m_d.s3 = m_q.s2;
    m_d.rise = m_q.s2 & ~m_q.s3;
    if (clear) begin
      m_d.cnt = hsrc_pkg::CNT_RST;
      m_d.meas = hsrc_pkg::CNT_RST;
    end else if (win_end) begin
      m_d.meas = m_q.cnt;
      m_d.cnt = m_q.rise ? 12'h001 : hsrc_pkg::CNT_RST;
    end else if (m_q.rise && m_q.cnt != hsrc_pkg::CNT_MAX) begin
      m_d.cnt = m_q.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign level = m_q.s3;
  assign rise = m_q.rise;
  assign meas = m_q.meas;

endmodule : hsrc_edge_meter

/* File: hw/hsrc_rx_clocking.sv */
`timescale 1ns/10ps
module hsrc_rx_clocking (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic REF_INPUT_A,
  input wire logic REF_INPUT_B,
  input wire logic REF_INPUT_C,
  input wire logic REF_INPUT_D,
  input wire logic REF_PAIR_SEL,
  input wire logic RECONFIG,
  input wire logic REF_SEL,
  input wire logic DEC_BYPASS,
  input wire logic LINK_CLK,
  input wire logic [hsrc_pkg::WORD_W-1:0] LINK_WORD,
  output logic [1:0] ACTIVE_REF,
  output logic CDR_LOCKED,
  output logic RECOVERED_WORD_CLOCK,
  output logic [hsrc_pkg::RATE_W-1:0] TX_BIT_RATE,
  output logic [hsrc_pkg::WORD_W-1:0] RX_PARALLEL_WORD,
  output logic [hsrc_pkg::COMP_W-1:0] RX_LUMA,
  output logic [hsrc_pkg::COMP_W-1:0] RX_CHROMA,
  output logic RX_WORD_VALID
);

  typedef struct packed {
    logic pair;
    logic [1:0] active;
    logic [hsrc_pkg::GATE_W-1:0] gate;
    logic win_end;
    logic eval;
    logic clear;
    logic locked;
    logic rec_clk;
    logic [hsrc_pkg::RATE_W-1:0] tx_rate;
    logic [hsrc_pkg::WORD_W-1:0] ld1;
    logic [hsrc_pkg::WORD_W-1:0] ld2;
    logic [hsrc_pkg::WORD_W-1:0] word;
    logic [hsrc_pkg::COMP_W-1:0] luma;
    logic [hsrc_pkg::COMP_W-1:0] chroma;
    logic valid;
  } hsrc_top_t;

  hsrc_top_t r_q;
  hsrc_top_t r_d;

  logic ref_raw;
  logic ref_level;
  logic ref_rise;
  logic link_level;
  logic link_rise;
  logic [hsrc_pkg::CNT_W-1:0] ref_meas;
  logic [hsrc_pkg::CNT_W-1:0] link_meas;

  function automatic logic [hsrc_pkg::RATE_W-1:0] times_mult(input logic [hsrc_pkg::CNT_W-1:0] c);
    times_mult = hsrc_pkg::RATE_W'(c) * hsrc_pkg::TX_MULT;
  endfunction : times_mult

  function automatic logic [hsrc_pkg::CNT_W-1:0] abs_diff(input logic [hsrc_pkg::CNT_W-1:0] a,
                                                          input logic [hsrc_pkg::CNT_W-1:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction : abs_diff

  // ----------------------------------------------------------------
  // Reference selection
  // ----------------------------------------------------------------
  // One selection feeds both the rate multiplier and the recovery loop
  always_comb begin
    case (r_q.active)
      2'h0: ref_raw = REF_INPUT_A;
      2'h1: ref_raw = REF_INPUT_B;
      2'h2: ref_raw = REF_INPUT_C;
      default: ref_raw = REF_INPUT_D;
    endcase
  end

  hsrc_edge_meter u_ref_meter (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .raw_in(ref_raw),
    .win_end(r_q.win_end),
    .clear(r_q.clear),
    .level(ref_level),
    .rise(ref_rise),
    .meas(ref_meas)
  );

  hsrc_edge_meter u_link_meter (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .raw_in(LINK_CLK),
    .win_end(r_q.win_end),
    .clear(r_q.clear),
    .level(link_level),
    .rise(link_rise),
    .meas(link_meas)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] want;
    logic rec_rise;
    logic [hsrc_pkg::WORD_W-1:0] cap;
    want = 2'h0;
    rec_rise = 1'b0;
    cap = hsrc_pkg::WORD_RST;
    r_d = r_q;
    r_d.ld1 = LINK_WORD;
    r_d.ld2 = r_q.ld1;
    r_d.win_end = 1'b0;
    r_d.eval = r_q.win_end;
    r_d.clear = 1'b0;
    r_d.valid = 1'b0;
    // The pair only moves on a reconfiguration
    if (RECONFIG) begin
      r_d.pair = REF_PAIR_SEL;
    end
    want = {r_d.pair, REF_SEL};
    if (want != r_q.active) begin
      r_d.active = want;
      r_d.clear = 1'b1;
      r_d.locked = 1'b0;
      r_d.eval = 1'b0;
      r_d.gate = hsrc_pkg::GATE_RST;
    end else if (r_q.gate == hsrc_pkg::GATE_LAST) begin
      r_d.gate = hsrc_pkg::GATE_RST;
      r_d.win_end = 1'b1;
    end else begin
      r_d.gate = r_q.gate + 11'h001;
    end
    // Lock needs a live reference close to the incoming word rate
    if (r_q.eval && !r_d.clear) begin
      r_d.tx_rate = times_mult(ref_meas);
      r_d.locked = (ref_meas != hsrc_pkg::CNT_RST) && (link_meas != hsrc_pkg::CNT_RST) &&
                   (abs_diff(ref_meas, link_meas) <= hsrc_pkg::LOCK_TOL);
    end
    // Recovered clock follows the stream when locked, else the reference
    r_d.rec_clk = r_q.locked ? link_level : ref_level;
    rec_rise = r_q.locked ? link_rise : ref_rise;
    if (rec_rise) begin
      cap[hsrc_pkg::BASE_W-1:0] = r_q.ld2[hsrc_pkg::BASE_W-1:0];
      cap[hsrc_pkg::WORD_W-1:hsrc_pkg::BASE_W] = DEC_BYPASS ? r_q.ld2[hsrc_pkg::WORD_W-1:hsrc_pkg::BASE_W] :
                                                 4'h0;
      r_d.word = cap;
      r_d.luma = cap[hsrc_pkg::LUMA_LSB +: hsrc_pkg::COMP_W];
      r_d.chroma = cap[hsrc_pkg::CHROMA_LSB +: hsrc_pkg::COMP_W];
      r_d.valid = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_q <= '0;
      r_q.pair <= hsrc_pkg::PAIR_RST;
      r_q.active <= hsrc_pkg::ACTIVE_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign ACTIVE_REF = r_q.active;
  assign CDR_LOCKED = r_q.locked;
  assign RECOVERED_WORD_CLOCK = r_q.rec_clk;
  assign TX_BIT_RATE = r_q.tx_rate;
  assign RX_PARALLEL_WORD = r_q.word;
  assign RX_LUMA = r_q.luma;
  assign RX_CHROMA = r_q.chroma;
  assign RX_WORD_VALID = r_q.valid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  a_tx_rate_mult: assert property ((r_q.eval && !r_d.clear) |=> TX_BIT_RATE == ($past(ref_meas) * 17'h00014))
    else $error("tx bit rate is not twenty times the reference count");

  a_lock_needs_ref: assert property ((CDR_LOCKED && !r_q.eval) |->
                                    (ref_meas != 12'h000 && link_meas != 12'h000))
    else $error("locked with a missing reference or stream");

  a_lock_tolerance: assert property ($rose(CDR_LOCKED) |-> abs_diff(ref_meas, link_meas) <= 12'h002)
    else $error("locked with reference too far from stream rate");

  a_pair_static: assert property ((ACTIVE_REF[1] != $past(ACTIVE_REF[1])) |-> $past(RECONFIG))
    else $error("reference pair changed without reconfiguration");

  a_sel_unlocks: assert property ((ACTIVE_REF != $past(ACTIVE_REF)) |-> !CDR_LOCKED ##1 !CDR_LOCKED)
    else $error("lock kept across a reference change");

  a_rec_follows_link: assert property ((CDR_LOCKED && $past(CDR_LOCKED)) |=> RECOVERED_WORD_CLOCK == $past(link_level))
    else $error("locked recovered clock does not follow the stream");

  a_rec_follows_ref: assert property ((!CDR_LOCKED && $past(!CDR_LOCKED)) |=> RECOVERED_WORD_CLOCK == $past(ref_level))
    else $error("unlocked recovered clock does not follow the reference");

  a_word_on_edge: assert property (!RX_WORD_VALID |-> $stable(RX_PARALLEL_WORD))
    else $error("parallel word changed without a word clock rise");

  a_extra_bits: assert property ((!DEC_BYPASS ##1 RX_WORD_VALID) |-> RX_PARALLEL_WORD[19:16] == 4'h0)
    else $error("extra word bits present with decoder in use");

  a_comp_split: assert property (RX_WORD_VALID |-> (RX_LUMA == RX_PARALLEL_WORD[19:10] &&
                                                   RX_CHROMA == RX_PARALLEL_WORD[9:0]))
    else $error("luma or chroma does not match the parallel word");

endmodule : hsrc_rx_clocking

/* File: verif/hsrc_far_model.sv */
`timescale 1ns/10ps
module hsrc_far_model (
  output logic ref_a,
  output logic ref_b,
  output logic ref_c,
  output logic ref_d,
  output logic link_clk,
  output logic [hsrc_pkg::WORD_W-1:0] link_word
);
  // ----------------------------------------------------------------
  // Oscillators: A and C match the link, B is the divided rate, D is absent
  // ----------------------------------------------------------------
  initial begin
    ref_d = 1'b0;
    link_word = 20'h00000;
  end
  initial begin
    ref_a = 1'b0;
    forever #80 ref_a = ~ref_a;
  end
  initial begin
    ref_b = 1'b0;
    forever #100 ref_b = ~ref_b;
  end
  initial begin
    ref_c = 1'b0;
    #37;
    forever #80 ref_c = ~ref_c;
  end
  initial begin
    link_clk = 1'b0;
    forever #80 link_clk = ~link_clk;
  end
  // Far side holds its receive reset over two full word clocks after power-up
  logic rx_side_reset;
  initial begin
    rx_side_reset = 1'b1;
    repeat (3) @(posedge link_clk);
    rx_side_reset = 1'b0;
  end
  // New word launched away from the capturing edge
  always @(negedge link_clk) begin
    link_word <= rx_side_reset ? 20'h00000 : hsrc_pkg::WORD_W'($urandom);
  end
endmodule : hsrc_far_model

/* File: verif/hsrc_rx_clocking_tb_top.sv */
`timescale 1ns/10ps
module hsrc_rx_clocking_tb_top;
  logic clk, rst_n, ref_a, ref_b, ref_c, ref_d, pair_sel, reconfig, ref_sel, bypass, link_clk;
  logic locked, valid, word_on;
  logic [1:0] active_ref;
  logic [hsrc_pkg::RATE_W-1:0] tx_rate;
  logic [hsrc_pkg::WORD_W-1:0] link_word, word_q, rx_word;
  logic [hsrc_pkg::COMP_W-1:0] luma, chroma;
  int fails, checked, pulses;
  logic rec_clk, rx_word_clock, rx_fabric_clock, tx_word_clock, tx_fabric_clock;
  int rises, tx_rises;

  hsrc_far_model hsrc_far_model_inst (.ref_a(ref_a), .ref_b(ref_b), .ref_c(ref_c), .ref_d(ref_d),
    .link_clk(link_clk), .link_word(link_word));

  hsrc_rx_clocking hsrc_rx_clocking_inst (.REF_CLK(clk), .RST_N(rst_n), .REF_INPUT_A(ref_a),
    .REF_INPUT_B(ref_b), .REF_INPUT_C(ref_c), .REF_INPUT_D(ref_d), .REF_PAIR_SEL(pair_sel),
    .RECONFIG(reconfig), .REF_SEL(ref_sel), .DEC_BYPASS(bypass), .LINK_CLK(link_clk),
    .LINK_WORD(link_word), .ACTIVE_REF(active_ref), .CDR_LOCKED(locked), .RECOVERED_WORD_CLOCK(rec_clk),
    .TX_BIT_RATE(tx_rate), .RX_PARALLEL_WORD(rx_word), .RX_LUMA(luma), .RX_CHROMA(chroma),
    .RX_WORD_VALID(valid));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Clock tree on the far side: buffered recovered clock feeds every user clock
  assign rx_word_clock = rec_clk;
  assign rx_fabric_clock = rx_word_clock;
  assign tx_word_clock = rx_word_clock;
  assign tx_fabric_clock = rx_fabric_clock;

  // Downstream logic runs in the one buffered domain
  always @(posedge rx_fabric_clock) begin
    rises++;
  end
  always @(posedge tx_word_clock) begin
    tx_rises++;
  end
  always @(posedge tx_fabric_clock) begin
    tx_rises++;
  end

  function automatic int exp_edges(input int per_ns);
    return hsrc_pkg::GATE_TIME_NS / per_ns;
  endfunction : exp_edges

  function automatic logic near(input int v, input int e);
    return (v >= e - 1) && (v <= e + 1);
  endfunction : near

  function automatic logic [hsrc_pkg::WORD_W-1:0] exp_word(input logic [hsrc_pkg::WORD_W-1:0] w, input logic b);
    return b ? w : {4'h0, w[15:0]};
  endfunction : exp_word

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc

  task automatic wait_lock();
    for (int i = 0; i < 1100 && locked !== 1'b1; i++) @(negedge clk);
  endtask : wait_lock

  task automatic count_for(input int n);
    pulses = 0;
    rises = 0;
    tx_rises = 0;
    wait_cyc(n);
  endtask : count_for

  task automatic stop_test();
    $display("Counts: checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // Word the far side presented at each link rise
  always @(posedge link_clk) begin
    word_q <= link_word;
  end

  always @(negedge clk) begin
    if (valid === 1'b1) begin
      pulses++;
      if (word_on) begin
        chk(rx_word === exp_word(word_q, bypass), "word content");
        chk({luma, chroma} === rx_word, "component split");
      end
    end
  end

  initial begin
    #(20 * 12000);
    fails++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(97037));
    {rst_n, pair_sel, reconfig, ref_sel, bypass, word_on} = 6'h00;
    wait_cyc(12);
    rst_n = 1'b1;
    chk(active_ref === 2'h0, "reset selection");
    wait_lock();
    chk(locked === 1'b1, "no lock on A");
    chk(int'(tx_rate) % 20 == 0 && near(int'(tx_rate) / 20, exp_edges(160)), "rate A");
    $display("Test lock_a done");
    for (int b = 0; b < 2; b++) begin
      bypass = b[0];
      word_on = 1'b1;
      count_for(8 * 40);
      word_on = 1'b0;
      chk(near(pulses, 40), "locked word rate");
      chk(near(rises, 40), "locked word clock rate");
      chk(tx_rises == 2 * rises, "transmit user clocks");
    end
    $display("Test words done");
    ref_sel = 1'b1;
    @(negedge clk);
    chk(active_ref === 2'h1 && locked === 1'b0, "switch to B");
    wait_cyc(2100);
    chk(locked === 1'b0, "lock on wrong rate");
    chk(near(int'(tx_rate) / 20, exp_edges(200)), "rate B");
    count_for(1000);
    chk(near(pulses, 20 * 1000 / 200), "unlocked word rate");
    chk(near(rises, 20 * 1000 / 200), "unlocked word clock rate");
    $display("Test ref_b done");
    pair_sel = 1'b1;
    wait_cyc($urandom_range(3, 9));
    chk(active_ref === 2'h1, "pair taken without reconfig");
    reconfig = 1'b1;
    ref_sel = 1'b0;
    @(negedge clk);
    reconfig = 1'b0;
    @(negedge clk);
    chk(active_ref === 2'h2, "reconfig to C");
    wait_lock();
    chk(locked === 1'b1, "no lock on C");
    ref_sel = 1'b1;
    wait_cyc(2100);
    chk(locked === 1'b0 && tx_rate === 17'h00000, "missing reference");
    count_for(500);
    chk(pulses == 0, "words without reference");
    chk(rises == 0, "word clock without reference");
    $display("Test pair_cd done");
    stop_test();
  end
endmodule : hsrc_rx_clocking_tb_top
